// ==== rtl/rfdw_defines.vh ====
// Constants for the receive frame descriptor writer: register map, control fields,
// descriptor layout and descriptor bit positions.
// Assumes byte addressing on both the register bus and the memory bus.
`ifndef RFDW_DEFINES_VH
`define RFDW_DEFINES_VH

// Register offsets (byte addresses).
`define RFDW_REG_CTRL 8'h00
`define RFDW_REG_STATUS 8'h04
`define RFDW_REG_RFD_HEAD 8'h08
`define RFDW_REG_SEG_BASE 8'h0C
`define RFDW_REG_FRAMES 8'h10

// Control register fields and reset value.
`define RFDW_CTRL_EN 0
`define RFDW_CTRL_MODE_LO 1
`define RFDW_CTRL_MODE_HI 2
`define RFDW_CTRL_FLEX 3
`define RFDW_CTRL_DA_LO 4
`define RFDW_CTRL_DA_HI 6
`define RFDW_CTRL_SA_LO 7
`define RFDW_CTRL_SA_HI 9
`define RFDW_CTRL_RESET 32'h0000_0330

// Addressing modes.
`define RFDW_MODE_LEGACY 2'h0
`define RFDW_MODE_SEG 2'h1
`define RFDW_MODE_LINEAR 2'h2

// Frame descriptor word offsets.
`define RFDW_RFD_STAT 32'h0000_0000
`define RFDW_RFD_LINK 32'h0000_0004
`define RFDW_RFD_RBDP 32'h0000_0008
`define RFDW_RFD_CNT 32'h0000_000C
`define RFDW_RFD_HDR 32'h0000_0010

// Buffer descriptor word offsets.
`define RFDW_RBD_CNT 32'h0000_0000
`define RFDW_RBD_NEXT 32'h0000_0004
`define RFDW_RBD_BUF 32'h0000_0008
`define RFDW_RBD_SIZE 32'h0000_000C

// Descriptor bit positions.
`define RFDW_BIT_EOF 15
`define RFDW_BIT_FILLED 14
`define RFDW_BIT_EL 15
`define RFDW_BIT_COMPLETE 15
`define RFDW_BIT_GROUP 1
`define RFDW_RFD_SIZE_LO 16
`define RFDW_CNT_W 14
`define RFDW_LEN_BYTES 14'h0002

`endif

// ==== rtl/rfdw_wbm.v ====
// Classic Wishbone master that runs one memory access per go pulse.
// Assumes the caller holds the request fields stable and waits for done.
`timescale 1ns/100ps
`default_nettype none

module rfdw_wbm (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Request from the engine.
  input wire go_i,
  input wire we_i,
  input wire [31:0] adr_i,
  input wire [31:0] dat_i,
  input wire [3:0] sel_i,
  output reg done_o,
  output reg [31:0] rdata_o,
  // Memory bus.
  output reg mem_cyc_o,
  output reg mem_stb_o,
  output reg mem_we_o,
  output reg [31:0] mem_adr_o,
  output reg [31:0] mem_dat_o,
  output reg [3:0] mem_sel_o,
  input wire [31:0] mem_dat_i,
  input wire mem_ack_i
);

  always @(posedge clk_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      rdata_o <= 32'h0000_0000;
      mem_cyc_o <= 1'b0;
      mem_stb_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_adr_o <= 32'h0000_0000;
      mem_dat_o <= 32'h0000_0000;
      mem_sel_o <= 4'h0;
    end else begin
      done_o <= 1'b0;
      if (mem_cyc_o && mem_ack_i) begin
        mem_cyc_o <= 1'b0;
        mem_stb_o <= 1'b0;
        done_o <= 1'b1;
        rdata_o <= mem_dat_i;
      end else if (go_i && !mem_cyc_o) begin
        mem_cyc_o <= 1'b1;
        mem_stb_o <= 1'b1;
        mem_we_o <= we_i;
        mem_adr_o <= {adr_i[31:2], 2'b00};
        mem_dat_o <= dat_i;
        mem_sel_o <= sel_i;
      end
    end
  end

endmodule // rfdw_wbm

`default_nettype wire

// ==== rtl/rfdw_regs.v ====
// Wishbone register slave for the frame descriptor writer.
// Assumes a classic single-cycle master; every access is answered one cycle later.
`timescale 1ns/100ps
`default_nettype none
`include "rfdw_defines.vh"

module rfdw_regs (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave.
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Engine side.
  output reg [31:0] ctrl_o,
  output reg [31:0] seg_base_o,
  output reg head_ld_o,
  output reg [31:0] head_o,
  input wire [31:0] status_i,
  input wire [31:0] frames_i,
  input wire [31:0] rfd_i
);

  wire wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  wire [7:0] adr_w = {wb_adr_i[7:2], 2'b00};

  // Byte-lane merge so partial writes only touch the selected lanes.
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] sel;
    integer i;
    begin
      merge = old_v;
      for (i = 0; i < 4; i = i + 1)
        if (sel[i])
          merge[i*8 +: 8] = new_v[i*8 +: 8];
    end
  endfunction

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_o <= `RFDW_CTRL_RESET;
      seg_base_o <= 32'h0000_0000;
      head_ld_o <= 1'b0;
      head_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      head_ld_o <= 1'b0;
      if (wr_en) begin
        case (adr_w)
          `RFDW_REG_CTRL: ctrl_o <= merge(ctrl_o, wb_dat_i, wb_sel_i);
          `RFDW_REG_SEG_BASE: seg_base_o <= merge(seg_base_o, wb_dat_i, wb_sel_i);
          `RFDW_REG_RFD_HEAD: begin
            head_o <= merge(head_o, wb_dat_i, wb_sel_i);
            head_ld_o <= 1'b1;
          end
          default: ;
        endcase
      end
      case (adr_w)
        `RFDW_REG_CTRL: wb_dat_o <= ctrl_o;
        `RFDW_REG_STATUS: wb_dat_o <= status_i;
        `RFDW_REG_RFD_HEAD: wb_dat_o <= rfd_i;
        `RFDW_REG_SEG_BASE: wb_dat_o <= seg_base_o;
        `RFDW_REG_FRAMES: wb_dat_o <= frames_i;
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule // rfdw_regs

`default_nettype wire

// ==== rtl/rfdw_top.v ====
// Receive frame descriptor writer: places each received frame's header and payload
// into host memory through frame and buffer descriptors, as a bus master.
// Assumes bytes arrive on clk_i from same-domain logic and memory answers with ack.
//
// Design decisions made here: the Wishbone register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "rfdw_defines.vh"

module rfdw_top (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Register bus.
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  // Received byte stream.
  input wire rx_valid_i,
  input wire [7:0] rx_data_i,
  input wire rx_last_i,
  output reg rx_ready_o,
  // Memory bus master.
  output wire mem_cyc_o,
  output wire mem_stb_o,
  output wire mem_we_o,
  output wire [31:0] mem_adr_o,
  output wire [31:0] mem_dat_o,
  output wire [3:0] mem_sel_o,
  input wire [31:0] mem_dat_i,
  input wire mem_ack_i,
  // Frame event.
  output reg frame_done_o
);

  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_WAIT = 4'h1;
  localparam [3:0] S_F1 = 4'h2;
  localparam [3:0] S_F2 = 4'h3;
  localparam [3:0] S_F3 = 4'h4;
  localparam [3:0] S_GET = 4'h5;
  localparam [3:0] S_PLACE = 4'h6;
  localparam [3:0] S_B1 = 4'h7;
  localparam [3:0] S_B2 = 4'h8;
  localparam [3:0] S_B3 = 4'h9;
  localparam [3:0] S_ADV = 4'hA;
  localparam [3:0] S_NEXT = 4'hB;
  localparam [3:0] S_END1 = 4'hC;
  localparam [3:0] S_END2 = 4'hD;
  localparam [3:0] S_END3 = 4'hE;
  localparam [3:0] S_END4 = 4'hF;

  wire [31:0] ctrl;
  wire [31:0] seg_base;
  wire head_ld;
  wire [31:0] head;
  wire op_done;
  wire [31:0] op_rdata;

  reg [3:0] state_r;
  reg [3:0] ret_r;
  reg op_go_r;
  reg op_we_r;
  reg [31:0] op_adr_r;
  reg [31:0] op_dat_r;
  reg [3:0] op_sel_r;
  reg [31:0] rfd_r;
  reg [31:0] link_r;
  reg [13:0] cap_r;
  reg [13:0] rfd_cnt_r;
  reg [13:0] pos_r;
  reg [7:0] byte_r;
  reg last_r;
  reg group_r;
  reg buf_ok_r;
  reg buf_none_r;
  reg buf_used_r;
  reg [31:0] rbd_r;
  reg [31:0] buf_next_r;
  reg [31:0] buf_addr_r;
  reg [13:0] buf_size_r;
  reg buf_el_r;
  reg [13:0] buf_cnt_r;
  reg [31:0] frames_r;

  wire [1:0] mode = ctrl[`RFDW_CTRL_MODE_HI:`RFDW_CTRL_MODE_LO];
  wire linear = (mode == `RFDW_MODE_LINEAR);
  wire [2:0] da_len = ctrl[`RFDW_CTRL_DA_HI:`RFDW_CTRL_DA_LO];
  wire [2:0] sa_len = ctrl[`RFDW_CTRL_SA_HI:`RFDW_CTRL_SA_LO];
  wire [13:0] hdr_len = {11'h000, da_len} + {11'h000, sa_len} + `RFDW_LEN_BYTES;
  wire [13:0] rfd_size = op_rdata[`RFDW_RFD_SIZE_LO +: `RFDW_CNT_W];
  wire busy = (state_r != S_IDLE);

  ////////////////////////////////////////////////////////////////////////////////
  // Pointer decoding, shared by the link, first buffer and next buffer fields.

  function [31:0] addr_of;
    input [31:0] ptr;
    input lin;
    input [31:0] base;
    begin
      addr_of = lin ? ptr : base + {16'h0000, ptr[15:0]};
    end
  endfunction

  function is_null;
    input [31:0] ptr;
    input lin;
    begin
      is_null = lin ? (ptr == 32'hFFFF_FFFF) : (ptr[15:0] == 16'hFFFF);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Register slave and memory master.

  rfdw_regs u_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .ctrl_o(ctrl),
    .seg_base_o(seg_base),
    .head_ld_o(head_ld),
    .head_o(head),
    .status_i({27'h0000000, state_r, busy}),
    .frames_i(frames_r),
    .rfd_i(rfd_r)
  );

  rfdw_wbm u_wbm (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .go_i(op_go_r),
    .we_i(op_we_r),
    .adr_i(op_adr_r),
    .dat_i(op_dat_r),
    .sel_i(op_sel_r),
    .done_o(op_done),
    .rdata_o(op_rdata),
    .mem_cyc_o(mem_cyc_o),
    .mem_stb_o(mem_stb_o),
    .mem_we_o(mem_we_o),
    .mem_adr_o(mem_adr_o),
    .mem_dat_o(mem_dat_o),
    .mem_sel_o(mem_sel_o),
    .mem_dat_i(mem_dat_i),
    .mem_ack_i(mem_ack_i)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Engine. Every memory access goes through S_WAIT and returns to ret_r.

  task issue;
    input we;
    input [31:0] adr;
    input [31:0] dat;
    input [3:0] sel;
    input [3:0] ret;
    begin
      op_go_r <= 1'b1;
      op_we_r <= we;
      op_adr_r <= adr;
      op_dat_r <= dat;
      op_sel_r <= sel;
      ret_r <= ret;
      state_r <= S_WAIT;
    end
  endtask

  // Byte writes put the byte on all lanes and select the lane from the low address bits.
  function [3:0] lane;
    input [1:0] a;
    begin
      lane = 4'h1 << a;
    end
  endfunction

  wire [31:0] hdr_adr = rfd_r + `RFDW_RFD_HDR + {18'h00000, rfd_cnt_r};
  wire [31:0] buf_adr = buf_addr_r + {18'h00000, buf_cnt_r};

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= S_IDLE;
      ret_r <= S_IDLE;
      op_go_r <= 1'b0;
      op_we_r <= 1'b0;
      op_adr_r <= 32'h0000_0000;
      op_dat_r <= 32'h0000_0000;
      op_sel_r <= 4'h0;
      rfd_r <= 32'h0000_0000;
      link_r <= 32'h0000_0000;
      cap_r <= 14'h0000;
      rfd_cnt_r <= 14'h0000;
      pos_r <= 14'h0000;
      byte_r <= 8'h00;
      last_r <= 1'b0;
      group_r <= 1'b0;
      buf_ok_r <= 1'b0;
      buf_none_r <= 1'b0;
      buf_used_r <= 1'b0;
      rbd_r <= 32'h0000_0000;
      buf_next_r <= 32'h0000_0000;
      buf_addr_r <= 32'h0000_0000;
      buf_size_r <= 14'h0000;
      buf_el_r <= 1'b0;
      buf_cnt_r <= 14'h0000;
      frames_r <= 32'h0000_0000;
      rx_ready_o <= 1'b0;
      frame_done_o <= 1'b0;
    end else begin
      op_go_r <= 1'b0;
      frame_done_o <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (head_ld)
            rfd_r <= head;
          else if (ctrl[`RFDW_CTRL_EN] && rx_valid_i)
            issue(1'b0, rfd_r + `RFDW_RFD_LINK, 32'h0000_0000, 4'hF, S_F1);
        end
        S_WAIT: begin
          if (op_done)
            state_r <= ret_r;
        end
        S_F1: begin
          link_r <= addr_of(op_rdata, linear, seg_base);
          issue(1'b0, rfd_r + `RFDW_RFD_RBDP, 32'h0000_0000, 4'hF, S_F2);
        end
        S_F2: begin
          buf_none_r <= is_null(op_rdata, linear);
          rbd_r <= addr_of(op_rdata, linear, seg_base);
          issue(1'b0, rfd_r + `RFDW_RFD_CNT, 32'h0000_0000, 4'hF, S_F3);
        end
        S_F3: begin
          // The mode, and with flex set the descriptor's header room, decide where each header byte lands.
          if (mode == `RFDW_MODE_LEGACY)
            cap_r <= 14'h0000;
          else if (!ctrl[`RFDW_CTRL_FLEX])
            cap_r <= hdr_len;
          else
            cap_r <= (rfd_size < hdr_len) ? rfd_size : hdr_len;
          rfd_cnt_r <= 14'h0000;
          pos_r <= 14'h0000;
          group_r <= 1'b0;
          buf_ok_r <= 1'b0;
          buf_used_r <= 1'b0;
          rx_ready_o <= 1'b1;
          state_r <= S_GET;
        end
        S_GET: begin
          if (rx_valid_i && rx_ready_o) begin
            byte_r <= rx_data_i;
            last_r <= rx_last_i;
            rx_ready_o <= 1'b0;
            if (pos_r == 14'h0000 && da_len != 3'h0)
              group_r <= rx_data_i[0];
            state_r <= S_PLACE;
          end
        end
        S_PLACE: begin
          if (rfd_cnt_r < cap_r) begin
            // Header bytes go to consecutive descriptor bytes in arrival order.
            rfd_cnt_r <= rfd_cnt_r + 14'h0001;
            issue(1'b1, hdr_adr, {4{byte_r}}, lane(hdr_adr[1:0]), S_NEXT);
          end else if (buf_none_r) begin
            state_r <= S_NEXT;
          end else if (!buf_ok_r) begin
            issue(1'b0, rbd_r + `RFDW_RBD_NEXT, 32'h0000_0000, 4'hF, S_B1);
          end else if (buf_cnt_r == buf_size_r && buf_el_r) begin
            // A full last-in-list buffer stays open for the frame end; further bytes are dropped.
            state_r <= S_NEXT;
          end else if (buf_cnt_r == buf_size_r) begin
            // A full buffer is marked filled with its count before moving on.
            issue(1'b1, rbd_r + `RFDW_RBD_CNT, {16'h0000, 1'b0, 1'b1, buf_cnt_r}, 4'h3, S_ADV);
          end else begin
            buf_cnt_r <= buf_cnt_r + 14'h0001;
            buf_used_r <= 1'b1;
            issue(1'b1, buf_adr, {4{byte_r}}, lane(buf_adr[1:0]), S_NEXT);
          end
        end
        S_B1: begin
          buf_next_r <= addr_of(op_rdata, linear, seg_base);
          issue(1'b0, rbd_r + `RFDW_RBD_BUF, 32'h0000_0000, 4'hF, S_B2);
        end
        S_B2: begin
          // Legacy buffers carry 24-bit addresses; the top byte is forced to zero.
          buf_addr_r <= (mode == `RFDW_MODE_LEGACY) ? {8'h00, op_rdata[23:0]} : op_rdata;
          issue(1'b0, rbd_r + `RFDW_RBD_SIZE, 32'h0000_0000, 4'hF, S_B3);
        end
        S_B3: begin
          // Odd sizes are not checked; software owes an even count.
          buf_size_r <= op_rdata[`RFDW_CNT_W-1:0];
          buf_el_r <= op_rdata[`RFDW_BIT_EL];
          buf_cnt_r <= 14'h0000;
          buf_ok_r <= 1'b1;
          state_r <= S_PLACE;
        end
        S_ADV: begin
          buf_ok_r <= 1'b0;
          buf_used_r <= 1'b0;
          rbd_r <= buf_next_r;
          state_r <= S_PLACE;
        end
        S_NEXT: begin
          pos_r <= pos_r + 14'h0001;
          if (last_r) begin
            state_r <= S_END1;
          end else begin
            rx_ready_o <= 1'b1;
            state_r <= S_GET;
          end
        end
        S_END1: begin
          if (buf_ok_r && buf_used_r)
            issue(1'b1, rbd_r + `RFDW_RBD_CNT, {16'h0000, 1'b1, 1'b1, buf_cnt_r}, 4'h3, S_END2);
          else
            state_r <= S_END2;
        end
        S_END2: begin
          // The descriptor's own end flag marks a frame that never reached a buffer.
          issue(1'b1, rfd_r + `RFDW_RFD_CNT, {16'h0000, !buf_used_r && !buf_ok_r, 1'b1, rfd_cnt_r},
                4'h3, S_END3);
        end
        S_END3: begin
          issue(1'b1, rfd_r + `RFDW_RFD_STAT,
                (32'h1 << `RFDW_BIT_COMPLETE) | ({31'h0, group_r} << `RFDW_BIT_GROUP), 4'h3, S_END4);
        end
        S_END4: begin
          rfd_r <= link_r;
          frames_r <= frames_r + 32'h0000_0001;
          frame_done_o <= 1'b1;
          state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

endmodule // rfdw_top

`default_nettype wire

// ==== bench/rfdw_mem.sv ====
// Behavioural host memory answering the writer's Wishbone master.
// Assumes all traffic falls in the 8 KiB window at 0x0000..0x1FFF.
`timescale 1ns/100ps
`default_nettype none
module rfdw_mem (
  // Clock, reset and answer latency.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] lat_i,
  // Wishbone slave side.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o
);
  logic [7:0] m [0:8191];
  logic [1:0] cnt_r;
  logic [10:0] w;
  assign w = adr_i[12:2];
  // Read data is inverted every idle cycle so a late sample of a stale word never looks right.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      cnt_r <= 2'h0;
      dat_o <= 32'h0;
    end else if (cyc_i && stb_i && !ack_o && cnt_r >= lat_i) begin
      ack_o <= 1'b1;
      cnt_r <= 2'h0;
      for (int k = 0; k < 4; k++) if (we_i && sel_i[k]) m[{w, k[1:0]}] <= dat_i[8*k +: 8];
      dat_o <= {m[{w, 2'h3}], m[{w, 2'h2}], m[{w, 2'h1}], m[{w, 2'h0}]};
    end else begin
      ack_o <= 1'b0;
      if (cyc_i && stb_i && !ack_o) cnt_r <= cnt_r + 2'h1;
      dat_o <= ~dat_o;
    end
  end
endmodule // rfdw_mem
`default_nettype wire

// ==== bench/rfdw_chk.sv ====
// Checker for the writer's top ports: bus handshakes, stream pacing, frame completion.
// Assumes it is bound into rfdw_top; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module rfdw_chk (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched ports.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic rx_valid_i,
  input wire logic rx_last_i,
  input wire logic rx_ready_o,
  input wire logic mem_cyc_o,
  input wire logic mem_stb_o,
  input wire logic mem_we_o,
  input wire logic [31:0] mem_adr_o,
  input wire logic [31:0] mem_dat_o,
  input wire logic [3:0] mem_sel_o,
  input wire logic mem_ack_i,
  input wire logic frame_done_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take; rx_valid_i && rx_ready_o; endsequence
  sequence s_last; rx_valid_i && rx_ready_o && rx_last_i; endsequence
  sequence s_wait; mem_cyc_o && mem_stb_o && !mem_ack_i; endsequence
  a_wb_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("register ack is not a one-cycle answer");
  a_take_drops: assert property (s_take |=> !rx_ready_o) else $error("ready stayed up after a take");
  a_mem_hold: assert property (s_wait |=> mem_cyc_o && mem_stb_o && $stable(mem_adr_o) && $stable(mem_dat_o)
    && $stable(mem_sel_o) && $stable(mem_we_o)) else $error("memory request changed before ack");
  a_mem_release: assert property (mem_cyc_o && mem_ack_i |=> !mem_cyc_o && !mem_stb_o)
    else $error("memory request not released after ack");
  a_read_lanes: assert property (mem_cyc_o && !mem_we_o |-> mem_sel_o == 4'hF) else $error("partial read");
  a_byte_copy: assert property (mem_cyc_o && mem_we_o && $onehot(mem_sel_o) |->
    mem_dat_o[31:8] == {3{mem_dat_o[7:0]}}) else $error("byte not copied on all lanes");
  a_count_half: assert property (mem_cyc_o && mem_we_o && !$onehot(mem_sel_o) |-> mem_sel_o == 4'h3)
    else $error("count word written outside low half");
  a_done_bound: assert property (s_last |-> ##[1:400] frame_done_o)
    else $error("frame not closed after its last byte");
  a_done_pulse: assert property (frame_done_o |=> !frame_done_o) else $error("frame done longer than a cycle");
  a_done_idle: assert property (frame_done_o |-> !rx_ready_o) else $error("ready high at frame close");
endmodule // rfdw_chk
`default_nettype wire

// ==== bench/rfdw_top_test.sv ====
// Bench for rfdw_top: four header layouts, two frames each over a two-entry cyclic list.
// Assumes rfdw_mem holds all descriptors and buffers; rfdw_chk is bound at the foot.
`timescale 1ns/100ps
`default_nettype none
module rfdw_top_test;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, rx_valid_i, rx_last_i, lin;
  logic wb_ack_o, rx_ready_o, mem_cyc_o, mem_stb_o, mem_we_o, mem_ack_i, frame_done_o;
  logic [7:0] wb_adr_i, rx_data_i;
  logic [31:0] wb_dat_i, wb_dat_o, mem_adr_o, mem_dat_o, mem_dat_i, rd;
  logic [3:0] wb_sel_i, mem_sel_o;
  logic [1:0] lat = 2'h0;
  logic [31:0] seed_r = 32'h532A2433;
  int bad_count = 0, check_count = 0, t, room, sz;
  int md[4] = '{0, 1, 2, 2};
  int fx[4] = '{0, 0, 0, 1};
  int dl[4] = '{6, 6, 0, 2};
  int sl[4] = '{6, 6, 3, 1};
  rfdw_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_last_i(rx_last_i), .rx_ready_o(rx_ready_o),
    .mem_cyc_o(mem_cyc_o), .mem_stb_o(mem_stb_o), .mem_we_o(mem_we_o), .mem_adr_o(mem_adr_o),
    .mem_dat_o(mem_dat_o), .mem_sel_o(mem_sel_o), .mem_dat_i(mem_dat_i), .mem_ack_i(mem_ack_i),
    .frame_done_o(frame_done_o));
  rfdw_mem mem (.clk_i(clk_i), .rst_i(rst_i), .lat_i(lat), .cyc_i(mem_cyc_o), .stb_i(mem_stb_o),
    .we_i(mem_we_o), .adr_i(mem_adr_o), .dat_i(mem_dat_o), .sel_i(mem_sel_o), .dat_o(mem_dat_i),
    .ack_o(mem_ack_i));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  function automatic logic [31:0] xs();
    seed_r ^= seed_r << 13;
    seed_r ^= seed_r >> 17;
    seed_r ^= seed_r << 5;
    return seed_r;
  endfunction
  // A fresh memory latency every cycle covers prompt and slow answers alike.
  always @(posedge clk_i) lat <= 2'(xs());
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
    if (n == 50) begin
      bad_count++;
      end_sim();
    end
  endtask
  task automatic mw(input int a, input logic [31:0] v);
    for (int k = 0; k < 4; k++) mem.m[a + k] = v[8*k +: 8];
  endtask
  function automatic logic [31:0] mr(input int a);
    return {mem.m[a + 3], mem.m[a + 2], mem.m[a + 1], mem.m[a]};
  endfunction
  function automatic logic [31:0] pt(input int off);
    return lin ? 32'h1000 + off : off;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic frame(input int receive_frame_descriptor, input int d, input int s, input int x);
    logic [7:0] q[$];
    int n, j, a;
    n = d + s + 8 + x;
    mw(32'h1200, 32'h0);
    mw(32'h1204, pt(32'h300));
    mw(32'h1208, 32'h1400);
    mw(32'h120C, 32'h4);
    mw(32'h1300, 32'h0);
    mw(32'h1304, pt(32'h380));
    mw(32'h1308, 32'h1500);
    mw(32'h130C, 32'h8010);
    for (j = 0; j < 32; j++) begin
      mem.m[32'h1400 + j] = 8'h0;
      mem.m[32'h1500 + j] = 8'h0;
    end
    for (j = 0; j < n; j++) q.push_back(8'(xs()));
    for (int i = 0; i < n; i++) begin
      rx_valid_i <= 1'b1;
      rx_data_i <= q[i];
      rx_last_i <= (i == n - 1);
      for (j = 0; j < 200 && rx_ready_o !== 1'b1; j++) @(posedge clk_i);
      if (j == 200) begin
        bad_count++;
        end_sim();
      end
      @(posedge clk_i);
    end
    rx_valid_i <= 1'b0;
    rx_last_i <= 1'b0;
    for (j = 0; j < 400 && frame_done_o !== 1'b1; j++) @(posedge clk_i);
    if (j == 400) begin
      bad_count++;
      end_sim();
    end
    // Bytes past the last-in-list buffer are dropped, so only the first room + 20 land anywhere.
    for (j = 0; j < n && j < room + 20; j++) begin
      a = j < room ? receive_frame_descriptor + 16 + j : (j - room < 4 ? 32'h1400 + j - room : 32'h1500 + j - room - 4);
      check("data byte", mem.m[a], q[j]);
    end
    check("frame status", mr(receive_frame_descriptor) & 32'h8002, {16'h0, 1'b1, 13'h0, d > 0 ? q[0][0] : 1'b0, 1'b0});
    check("frame count word", mr(receive_frame_descriptor + 12), (sz << 16) | 32'h4000 | room);
    check("first buffer", mr(32'h1200) & 32'hFFFF, 32'h4004);
    check("last buffer", mr(32'h1300) & 32'hFFFF, 32'hC000 | (n - room > 20 ? 16 : n - room - 4));
    check("past last buffer", mem.m[32'h1510], 8'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, rx_valid_i, rx_last_i, lin} = 6'h0;
    {wb_adr_i, rx_data_i, wb_dat_i} = 48'h0;
    wb_sel_i = 4'hF;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, 8'h00, 32'h0);
    check("ctrl reset", rd, 32'h330);
    wb(1'b1, 8'h20, 32'hFFFFFFFF);
    wb(1'b0, 8'h20, 32'h0);
    check("unmapped", rd, 32'h0);
    for (t = 0; t < 4; t++) begin
      lin = md[t] == 2;
      room = md[t] == 0 ? 0 : (fx[t] ? 3 : dl[t] + sl[t] + 2);
      sz = fx[t] ? 3 : 32'h20;
      mw(32'h1100, 32'h0);
      mw(32'h1104, pt(32'h180));
      mw(32'h1108, pt(32'h200));
      mw(32'h110C, sz << 16);
      mw(32'h1180, 32'h0);
      mw(32'h1184, pt(32'h100));
      mw(32'h1188, pt(32'h200));
      mw(32'h118C, sz << 16);
      for (int j = 0; j < 32; j++) {mem.m[32'h1110 + j], mem.m[32'h1190 + j]} = 16'h0;
      wb(1'b1, 8'h00, (md[t] << 1) | (fx[t] << 3) | (dl[t] << 4) | (sl[t] << 7));
      wb(1'b1, 8'h0C, 32'h1000);
      wb(1'b1, 8'h08, 32'h1100);
      wb(1'b1, 8'h00, 1 | (md[t] << 1) | (fx[t] << 3) | (dl[t] << 4) | (sl[t] << 7));
      frame(32'h1100, dl[t], sl[t], 0);
      frame(32'h1180, dl[t], sl[t], 16);
      wb(1'b0, 8'h10, 32'h0);
      check("frames", rd, 2 * t + 2);
      wb(1'b0, 8'h04, 32'h0);
      check("status idle", rd, 32'h0);
      wb(1'b0, 8'h08, 32'h0);
      check("list head", rd, 32'h1100);
      $display("layout %0d done", t);
    end
    end_sim();
  end
endmodule // rfdw_top_test
bind rfdw_top rfdw_chk chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .rx_valid_i(rx_valid_i), .rx_last_i(rx_last_i), .rx_ready_o(rx_ready_o),
  .mem_cyc_o(mem_cyc_o), .mem_stb_o(mem_stb_o), .mem_we_o(mem_we_o), .mem_adr_o(mem_adr_o),
  .mem_dat_o(mem_dat_o), .mem_sel_o(mem_sel_o), .mem_ack_i(mem_ack_i), .frame_done_o(frame_done_o));
`default_nettype wire
